// ---- scd_strap_config.sv ----
// Strap capture and host decode control for the host-bus IDE controller.
// Assumes straps are stable at reset release; APB and host cycles on CLK.
// What this block does
// - Identity port decoded only when id_decode_strap is high.
// - id_port_addr_strap low selects 178h, high selects 078h.
// - bar_enable_strap low makes every base register read zero.
// - Straps off: primary irq on line 14, secondary on line 15.
// - Straps off: task files decode at 1Fx and 17x.
// - bar_enable_strap high: base registers writable, fixed legacy decode off.
// - Chip select straps form two-bit code picking one of four identities.
// - Identity port write of a wrong value disables the whole device.
// - Drive address register strap low enables 3F7/377 decode, bars off.
// - Straps sampled at reset release and held until next reset.
//
// The APB slave port and the placing of the registers were chosen for this implementation.
`timescale 1ns/100ps
module scd_strap_config
#(
    parameter logic [7:0] ID_BASE = 8'h20  // Arbitrary identity base value
)
(
    input  wire logic        CLK,
    input  wire logic        RESETN,
    input  wire logic        PSEL,
    input  wire logic        PENABLE,
    input  wire logic        PWRITE,
    input  wire logic [7:0]  PADDR,
    input  wire logic [31:0] PWDATA,
    output logic      [31:0] PRDATA,
    output logic             PREADY,
    output logic             PSLVERR,
    input  wire logic        ID_DECODE_STRAP,
    input  wire logic        BAR_ENABLE_STRAP,
    input  wire logic        ID_PORT_ADDR_STRAP,
    input  wire logic        CHIP_SELECT_HIGH_STRAP,
    input  wire logic        CHIP_SELECT_LOW_STRAP,
    input  wire logic        DRIVE_ADDR_REG_DECODE_STRAP,
    input  wire logic        PRI_DRIVE_IRQ,
    input  wire logic        SEC_DRIVE_IRQ,
    output logic             LEGACY_PRIMARY_INTERRUPT,
    output logic             LEGACY_SECONDARY_INTERRUPT,
    output logic             NATIVE_INTERRUPT,
    output logic             CHIP_ENABLED,
    output logic [4:0]       HOST_DECODE
);
    typedef enum logic [1:0]
    {
        ST_CAPTURE = 2'b01,
        ST_RUN     = 2'b10
    } scd_state_t;

    scd_state_t            state_q;
    scd_pkg::scd_straps_t  straps_q;
    scd_pkg::scd_straps_t  pins;
    scd_pkg::scd_decode_t  dec;
    scd_pkg::scd_host_cyc_t cyc;
    logic [31:0]           bar_q [4];
    logic [7:0]            programming_interface_reg_q;
    logic                  enabled_q;
    logic [7:0]            chip_id;
    logic [15:0]           id_port;
    logic                  apb_wr;
    logic                  apb_rd;
    logic                  host_go;
    logic [2:0]            bar_idx;
    logic                  bar_hit;

    assign pins = '{ID_DECODE_STRAP, BAR_ENABLE_STRAP, ID_PORT_ADDR_STRAP,
                    CHIP_SELECT_HIGH_STRAP, CHIP_SELECT_LOW_STRAP,
                    DRIVE_ADDR_REG_DECODE_STRAP};
    assign chip_id = ID_BASE + {6'h00, straps_q.chip_select_high_strap,
                     straps_q.chip_select_low_strap};
    assign id_port = straps_q.id_port_addr_strap ? scd_pkg::SCD_ID_PORT_HI
                     : scd_pkg::SCD_ID_PORT_LO;
    assign apb_wr  = PSEL && PENABLE && PWRITE && PREADY;
    assign apb_rd  = PSEL && !PWRITE;
    assign cyc     = '{PWDATA[scd_pkg::SCD_HIO_CFG_BIT],
                       PWDATA[scd_pkg::SCD_HIO_WR_BIT],
                       PWDATA[scd_pkg::SCD_HIO_ADDR_LSB +: 16],
                       PWDATA[scd_pkg::SCD_HIO_DATA_LSB +: 8]};
    assign host_go = apb_wr && PADDR == scd_pkg::SCD_OFS_HOSTIO
                     && state_q == ST_RUN;
    assign bar_idx = 3'((PADDR - scd_pkg::SCD_OFS_BAR0) >> 2);
    assign bar_hit = PADDR >= scd_pkg::SCD_OFS_BAR0
                     && PADDR <= scd_pkg::SCD_OFS_BAR3;

    scd_legacy_decode u_dec
    (
        .ADDR    (cyc.addr),
        .STRAPS  (straps_q),
        .ID_PORT (id_port),
        .DEC     (dec)
    );

    // Strap capture on the first edge after release, never under reset
    always_ff @(posedge CLK or negedge RESETN)
    begin
        if (!RESETN)
        begin
            state_q  <= ST_CAPTURE;
            straps_q <= '0;
        end
        else if (state_q == ST_CAPTURE)
        begin
            straps_q <= pins;
            state_q  <= ST_RUN;
        end
    end

    // Identity port writes switch the whole chip off or back on
    always_ff @(posedge CLK or negedge RESETN)
    begin
        if (!RESETN)
            enabled_q <= 1'b1;
        else if (host_go && !cyc.cfg && cyc.wr && dec.id_port)
            enabled_q <= cyc.data == chip_id;
    end

    // Base registers and programming interface, APB writes while enabled only
    always_ff @(posedge CLK or negedge RESETN)
    begin
        if (!RESETN)
        begin
            for (int i = 0; i < 4; i++)
                bar_q[i] <= scd_pkg::SCD_BAR_RESET;
            programming_interface_reg_q <= scd_pkg::SCD_PROG_IF_RST;
        end
        else if (apb_wr && enabled_q && state_q == ST_RUN)
        begin
            // Writes dropped while strapped off, so reads stay zero
            if (bar_hit && straps_q.bar_enable_strap)
                bar_q[bar_idx[1:0]] <= PWDATA
                                       & scd_pkg::SCD_BAR_MASK;
            if (PADDR == scd_pkg::SCD_OFS_PROG_IF)
                programming_interface_reg_q <= PWDATA[7:0];
        end
    end

    // Interrupt routing; legacy lines with base registers off or the channel's native bit clear
    always_ff @(posedge CLK or negedge RESETN)
    begin
        if (!RESETN)
        begin
            LEGACY_PRIMARY_INTERRUPT   <= 1'b0;
            LEGACY_SECONDARY_INTERRUPT <= 1'b0;
            NATIVE_INTERRUPT           <= 1'b0;
        end
        else
        begin
            LEGACY_PRIMARY_INTERRUPT <= enabled_q && PRI_DRIVE_IRQ
                && (!straps_q.bar_enable_strap
                || !programming_interface_reg_q[0]);
            LEGACY_SECONDARY_INTERRUPT <= enabled_q && SEC_DRIVE_IRQ
                && (!straps_q.bar_enable_strap
                || !programming_interface_reg_q[2]);
            NATIVE_INTERRUPT <= enabled_q && straps_q.bar_enable_strap
                && ((PRI_DRIVE_IRQ && programming_interface_reg_q[0])
                || (SEC_DRIVE_IRQ
                && programming_interface_reg_q[2]));
        end
    end

    // Latched decode of the last host cycle; only the identity port hits while disabled
    always_ff @(posedge CLK or negedge RESETN)
    begin
        if (!RESETN)
            HOST_DECODE <= '0;
        else if (host_go)
            HOST_DECODE <= (enabled_q && !cyc.cfg) ? dec
                           : {4'h0, dec.id_port};
    end

    always_ff @(posedge CLK or negedge RESETN)
    begin
        if (!RESETN)
            CHIP_ENABLED <= 1'b1;
        else
            CHIP_ENABLED <= enabled_q;
    end

    // APB answer: no wait states, read data registered in setup
    always_ff @(posedge CLK or negedge RESETN)
    begin
        if (!RESETN)
        begin
            PREADY  <= 1'b0;
            PRDATA  <= '0;
            PSLVERR <= 1'b0;
        end
        else
        begin
            PREADY  <= PSEL && !PENABLE;
            PSLVERR <= PSEL && !PENABLE && PADDR > scd_pkg::SCD_OFS_HOSTIO;
            if (apb_rd && !PENABLE)
            begin
                PRDATA <= '0;
                if (bar_hit)
                    PRDATA <= (straps_q.bar_enable_strap && enabled_q)
                              ? bar_q[bar_idx[1:0]] : '0;
                else if (PADDR == scd_pkg::SCD_OFS_STRAP)
                    PRDATA <= {26'h0, straps_q};
                else if (PADDR == scd_pkg::SCD_OFS_STATUS)
                    PRDATA <= {7'h00, enabled_q, id_port, chip_id};
                else if (PADDR == scd_pkg::SCD_OFS_PROG_IF && enabled_q)
                    PRDATA <= {24'h0, programming_interface_reg_q};
            end
        end
    end
endmodule : scd_strap_config

// ---- scd_pkg.sv ----
// Package for the strap configuration decoder: APB map, fields, constants.
// Assumes a 32-bit APB master and strap pins stable around reset release.
package scd_pkg;

    // APB register byte offsets
    localparam logic [7:0] SCD_OFS_STRAP   = 8'h00;
    localparam logic [7:0] SCD_OFS_STATUS  = 8'h04;
    localparam logic [7:0] SCD_OFS_BAR0    = 8'h08;
    localparam logic [7:0] SCD_OFS_BAR1    = 8'h0C;
    localparam logic [7:0] SCD_OFS_BAR2    = 8'h10;
    localparam logic [7:0] SCD_OFS_BAR3    = 8'h14;
    localparam logic [7:0] SCD_OFS_PROG_IF = 8'h18;
    localparam logic [7:0] SCD_OFS_HOSTIO  = 8'h1C;

    // Host cycle register fields
    localparam int SCD_HIO_DATA_LSB = 0;
    localparam int SCD_HIO_ADDR_LSB = 8;
    localparam int SCD_HIO_WR_BIT   = 24;
    localparam int SCD_HIO_CFG_BIT  = 25;

    // Identity port addresses and legacy decodes
    localparam logic [15:0] SCD_ID_PORT_LO  = 16'h0178;
    localparam logic [15:0] SCD_ID_PORT_HI  = 16'h0078;
    localparam logic [11:0] SCD_PRI_TF_BASE = 12'h01F;
    localparam logic [11:0] SCD_SEC_TF_BASE = 12'h017;
    localparam logic [15:0] SCD_PRI_DAR     = 16'h03F7;
    localparam logic [15:0] SCD_SEC_DAR     = 16'h0377;

    // Reset values and base register write mask
    localparam logic [31:0] SCD_BAR_RESET   = 32'h0000_0000;
    localparam logic [7:0]  SCD_PROG_IF_RST = 8'h00;
    localparam logic [31:0] SCD_BAR_MASK    = 32'hFFFF_FFFC;

    // Captured strap set
    typedef struct packed {
        logic       id_decode_strap;
        logic       bar_enable_strap;
        logic       id_port_addr_strap;
        logic       chip_select_high_strap;
        logic       chip_select_low_strap;
        logic       drive_addr_reg_decode_strap;
    } scd_straps_t;

    // Host I/O or configuration cycle
    typedef struct packed {
        logic        cfg;
        logic        wr;
        logic [15:0] addr;
        logic [7:0]  data;
    } scd_host_cyc_t;

    // Decode results for one host cycle
    typedef struct packed {
        logic pri_tf;
        logic sec_tf;
        logic pri_dar;
        logic sec_dar;
        logic id_port;
    } scd_decode_t;

endpackage : scd_pkg

// ---- scd_legacy_decode.sv ----
// Legacy I/O address decoder for the task files and drive address ports.
// Assumes the address is stable for the cycle it is presented in.
`timescale 1ns/100ps
module scd_legacy_decode
(
    input  wire logic [15:0]           ADDR,
    input  wire scd_pkg::scd_straps_t  STRAPS,
    input  wire logic [15:0]           ID_PORT,
    output scd_pkg::scd_decode_t       DEC
);
    always_comb
    begin
        DEC = '0;
        // Fixed map only while the base registers are strapped off
        if (!STRAPS.bar_enable_strap)
        begin
            DEC.pri_tf = ADDR[15:4] == scd_pkg::SCD_PRI_TF_BASE;
            DEC.sec_tf = ADDR[15:4] == scd_pkg::SCD_SEC_TF_BASE;
            DEC.pri_dar = !STRAPS.drive_addr_reg_decode_strap
                && ADDR == scd_pkg::SCD_PRI_DAR;
            DEC.sec_dar = !STRAPS.drive_addr_reg_decode_strap
                && ADDR == scd_pkg::SCD_SEC_DAR;
        end
        DEC.id_port = STRAPS.id_decode_strap && ADDR == ID_PORT;
    end
endmodule : scd_legacy_decode

// ---- scd_strap_asserts.sv ----
// Port checker for the strap decoder, bound to its top module.
// Assumes straps are steady at the first edge after reset release.
`timescale 1ns/100ps
module scd_strap_asserts
#(
    parameter logic [7:0] ID_BASE = 8'h20
)
(
    input wire logic        CLK,
    input wire logic        RESETN,
    input wire logic        PSEL,
    input wire logic        PENABLE,
    input wire logic        PWRITE,
    input wire logic [7:0]  PADDR,
    input wire logic [31:0] PWDATA,
    input wire logic [31:0] PRDATA,
    input wire logic        PREADY,
    input wire logic        ID_DECODE_STRAP,
    input wire logic        BAR_ENABLE_STRAP,
    input wire logic        ID_PORT_ADDR_STRAP,
    input wire logic        CHIP_SELECT_HIGH_STRAP,
    input wire logic        CHIP_SELECT_LOW_STRAP,
    input wire logic        DRIVE_ADDR_REG_DECODE_STRAP,
    input wire logic        PRI_DRIVE_IRQ,
    input wire logic        LEGACY_PRIMARY_INTERRUPT,
    input wire logic        CHIP_ENABLED,
    input wire logic [4:0]  HOST_DECODE
);
    logic       first_q;
    logic [5:0] cap_q;
    wire        acc = PSEL && PENABLE && PREADY;
    wire        hw = acc && PWRITE && PADDR == 8'h1C && PWDATA[25:24] == 2'b01;
    wire [15:0] ha = PWDATA[23:8];
    wire [15:0] idp = cap_q[3] ? 16'h0078 : 16'h0178;
    wire [7:0]  idv = ID_BASE + {6'h00, cap_q[2:1]};
    wire        idw = hw && cap_q[5] && ha == idp;
    wire        dar = !cap_q[0];
    wire [4:0]  dec = {ha[15:4] == 12'h01F, ha[15:4] == 12'h017,
                       ha == 16'h03F7 && dar, ha == 16'h0377 && dar, idw};
    // Own copy of the straps, so a late pin change cannot fool us
    always_ff @(posedge CLK or negedge RESETN)
    begin
        if (!RESETN)
            first_q <= 1'b1;
        else
            first_q <= 1'b0;
    end
    always_ff @(posedge CLK)
    begin
        if (first_q && RESETN)
            cap_q <= {ID_DECODE_STRAP, BAR_ENABLE_STRAP, ID_PORT_ADDR_STRAP,
                      CHIP_SELECT_HIGH_STRAP, CHIP_SELECT_LOW_STRAP,
                      DRIVE_ADDR_REG_DECODE_STRAP};
    end
    default clocking cb @(posedge CLK);
    endclocking
    default disable iff (!RESETN);
    property p_off; !first_q && !cap_q[5] |-> CHIP_ENABLED; endproperty
    a_off: assert property (p_off) else $error("Id decode off");
    property p_dec; hw && !first_q && !cap_q[4] && CHIP_ENABLED
        |=> HOST_DECODE == $past(dec); endproperty
    a_dec: assert property (p_dec) else $error("Bad host decode");
    property p_bz; acc && !PWRITE && PADDR inside {8'h08, 8'h0C, 8'h10, 8'h14}
        && !first_q && !cap_q[4] |-> PRDATA == 32'h0000_0000; endproperty
    a_bz: assert property (p_bz) else $error("Base reg not zero");
    // Enable output lags the internal flag, so look one edge later
    property p_irq; !first_q && !cap_q[4] && PRI_DRIVE_IRQ ##1 CHIP_ENABLED
        |-> LEGACY_PRIMARY_INTERRUPT; endproperty
    a_irq: assert property (p_irq) else $error("No legacy irq");
    property p_kill; idw && PWDATA[7:0] != idv |-> ##[1:3] !CHIP_ENABLED;
    endproperty
    a_kill: assert property (p_kill) else $error("Still enabled");
    property p_rev; idw && PWDATA[7:0] == idv |-> ##[1:3] CHIP_ENABLED;
    endproperty
    a_rev: assert property (p_rev) else $error("Not re-enabled");
    property p_hold; !CHIP_ENABLED && !idw && !$past(idw) |=> !CHIP_ENABLED;
    endproperty
    a_hold: assert property (p_hold) else $error("Woke up alone");
    property p_strap; acc && !PWRITE && PADDR == 8'h00 && !first_q
        |-> PRDATA[5:0] == cap_q; endproperty
    a_strap: assert property (p_strap) else $error("Strap drift");
    c_kill: cover property (idw && PWDATA[7:0] != idv);
    c_irq: cover property (LEGACY_PRIMARY_INTERRUPT);
    c_bar: cover property (acc && !PWRITE && PADDR == 8'h08);
endmodule : scd_strap_asserts
bind scd_strap_config scd_strap_asserts #(.ID_BASE(ID_BASE)) u_chk (.*);

// ---- scd_far_side.sv ----
// Far-side model: strap resistors and drive interrupt lines.
// Assumes the bench sets the strap pattern before reset release.
`timescale 1ns/100ps
module scd_far_side
(
    input  wire logic [5:0]      CFG,
    input  wire logic [1:0]      IRQ,
    output scd_pkg::scd_straps_t STRAPS,
    output logic [1:0]           DRIVE_IRQ
);
    // Resistors, so pins stay put through reset
    assign STRAPS = scd_pkg::scd_straps_t'(CFG);
    assign DRIVE_IRQ = IRQ;
endmodule : scd_far_side

// ---- tb_strap_config_decode.sv ----
// Bench for the strap decoder: APB tasks and directed checks.
// Assumes the far-side model supplies straps and drive interrupts.
`timescale 1ns/100ps
module tb_strap_config_decode;
    localparam logic [7:0] IDB = 8'h20;  // Arbitrary identity base
    logic        clk = 1'b0;
    logic        resetn = 1'b0;
    logic        psel = 1'b0;
    logic        pen = 1'b0;
    logic        pwr = 1'b0;
    logic [7:0]  padr = 8'h00;
    logic [31:0] pwd = 32'h0000_0000;
    logic [31:0] prd, rd;
    logic        rdy, slv, err, lp, ls, ce, ni;
    logic [4:0]  hd;
    logic [5:0]  cfg = 6'h00;
    logic [1:0]  irq = 2'b00;
    logic [1:0]  dirq;
    logic [15:0] ta [5] = '{16'h01F3, 16'h0173, 16'h03F7, 16'h0377,
                            16'h0078};
    logic [4:0]  td [5] = '{5'h10, 5'h08, 5'h04, 5'h02, 5'h01};
    scd_pkg::scd_straps_t st;
    int          n_errors = 0;
    int          tests_run = 0;
`define SCD_CHK(a, b) begin tests_run++; if ((a) !== (b)) begin n_errors++; \
    $display("mismatch at %0t: got %h", $time, a); end end
    always #20 clk = ~clk;
    scd_strap_config #(.ID_BASE(IDB)) dut
    (
        .CLK(clk), .RESETN(resetn), .PSEL(psel), .PENABLE(pen),
        .PWRITE(pwr), .PADDR(padr), .PWDATA(pwd), .PRDATA(prd),
        .PREADY(rdy), .PSLVERR(slv),
        .ID_DECODE_STRAP(st.id_decode_strap),
        .BAR_ENABLE_STRAP(st.bar_enable_strap),
        .ID_PORT_ADDR_STRAP(st.id_port_addr_strap),
        .CHIP_SELECT_HIGH_STRAP(st.chip_select_high_strap),
        .CHIP_SELECT_LOW_STRAP(st.chip_select_low_strap),
        .DRIVE_ADDR_REG_DECODE_STRAP(st.drive_addr_reg_decode_strap),
        .PRI_DRIVE_IRQ(dirq[1]), .SEC_DRIVE_IRQ(dirq[0]),
        .LEGACY_PRIMARY_INTERRUPT(lp), .LEGACY_SECONDARY_INTERRUPT(ls),
        .NATIVE_INTERRUPT(ni), .CHIP_ENABLED(ce), .HOST_DECODE(hd)
    );
    scd_far_side far (.CFG(cfg), .IRQ(irq), .STRAPS(st), .DRIVE_IRQ(dirq));
    task automatic conclude;
        $display("checks %0d mismatches %0d", tests_run, n_errors);
        if (n_errors == 0 && tests_run > 0)
            $display("All tests passed");
        else
            $display("Some tests failed");
        $finish;
    endtask : conclude
    // Holds the request until ready is seen, for up to 16 extra edges
    task automatic apb(input logic w, input logic [7:0] a,
                       input logic [31:0] d);
        int k;
        psel <= 1'b1;
        pwr <= w;
        padr <= a;
        pwd <= d;
        @(posedge clk);
        pen <= 1'b1;
        @(posedge clk);
        for (k = 0; k < 16 && rdy !== 1'b1; k++)
            @(posedge clk);
        if (k == 16)
        begin
            n_errors++;
            $display("mismatch at %0t: no ready", $time);
        end
        rd = prd;
        err = slv;
        psel <= 1'b0;
        pen <= 1'b0;
        @(posedge clk);
    endtask : apb
    // Extra edges cover the enable flag lag
    task automatic host(input logic [15:0] a, input logic [7:0] d);
        apb(1'b1, 8'h1C, {6'h00, 2'b01, a, d});
        repeat (2) @(posedge clk);
    endtask : host
    task automatic rst(input logic [5:0] c);
        resetn <= 1'b0;
        cfg <= c;
        repeat (3) @(posedge clk);
        resetn <= 1'b1;
        repeat (2) @(posedge clk);
    endtask : rst
    initial
    begin
        for (int cs = 0; cs < 4; cs++)
        begin
            rst({3'b101, cs[1:0], 1'b0});
            apb(1'b0, 8'h04, 32'h0000_0000);
            `SCD_CHK(rd, {8'h01, 16'h0078, IDB + 8'(cs)})
        end
        $display("test identity done");
        apb(1'b1, 8'h08, 32'hFFFF_FFFF);
        apb(1'b0, 8'h08, 32'h0000_0000);
        `SCD_CHK(rd, 32'h0000_0000)
        foreach (ta[i])
        begin
            host(ta[i], 8'h23);
            `SCD_CHK(hd, td[i])
        end
        irq <= 2'b11;
        repeat (3) @(posedge clk);
        `SCD_CHK({lp, ls}, 2'b11)
        irq <= 2'b00;
        host(16'h0078, 8'h55);
        `SCD_CHK(ce, 1'b0)
        host(16'h01F0, 8'h23);
        `SCD_CHK(ce, 1'b0)
        `SCD_CHK(hd, 5'h00)
        host(16'h0078, 8'h23);
        `SCD_CHK(ce, 1'b1)
        cfg <= 6'h00;
        apb(1'b0, 8'h00, 32'h0000_0000);
        `SCD_CHK(rd, 32'h0000_002E)
        apb(1'b0, 8'h20, 32'h0000_0000);
        `SCD_CHK(err, 1'b1)
        $display("test legacy done");
        rst(6'h11);
        apb(1'b1, 8'h08, 32'hFFFF_FFFF);
        apb(1'b0, 8'h08, 32'h0000_0000);
        `SCD_CHK(rd, 32'hFFFF_FFFC)
        // Both channels native: drive irqs leave the legacy lines alone
        apb(1'b1, 8'h18, 32'h0000_0005);
        irq <= 2'b11;
        repeat (3) @(posedge clk);
        `SCD_CHK({lp, ls, ni}, 3'b001)
        irq <= 2'b00;
        host(16'h0178, 8'h55);
        `SCD_CHK(ce, 1'b1)
        apb(1'b0, 8'h04, 32'h0000_0000);
        `SCD_CHK(rd, 32'h0101_7820)
        $display("test native done");
        conclude();
    end
    initial
    begin
        #200000;
        n_errors++;
        conclude();
    end
endmodule : tb_strap_config_decode
